// ==== rtl/src_core.sv ====
// core control: register file, alu, fetch/execute, stack, sleep, interrupts
//
// How it works
// - thirty-two eight-bit working registers, any read or written each cycle
// - two operands read, alu computes, result written back in one cycle
// - alu works register-register, register-immediate and on one register
// - program memory and data/io use separate storage and separate buses
// - next instruction is prefetched while the current one executes
// - every instruction is one sixteen-bit word at one program address
// - relative jump and call reach all 512 program addresses
// - call and interrupt push return address onto three-entry hardware stack
// - i/o space has 64 locations for peripheral registers
// - interrupt control lives in i/o space; status i-bit gates all
// - each interrupt source branches to its own vector near address zero
// - of several pending interrupts the lowest vector is served first
// - idle stops execution while registers and interrupt logic keep running
// - power-down keeps registers, stops oscillator until external interrupt or reset
// - a low reset level resets the device even without a running clock
// - while reset is low all port pins are high impedance
`timescale 1ns/10ps
`default_nettype none
module src_core
    import src_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET_N,
    output logic [IP_W-1:0] PMEM_ADDR,
    input wire logic [IW-1:0] PMEM_DATA,
    output var src_iobus_t IO_BUS,
    input wire logic [DW-1:0] IO_RDATA,
    input wire logic [NUM_PIRQ-1:0] IRQ_REQ,
    output logic [NUM_IRQ-1:0] IRQ_ACK,
    input wire logic EXT_INT_N,
    output logic OSC_STOP,
    output logic SLEEPING,
    input wire logic [PB_W-1:0] PB_IN,
    output logic [PB_W-1:0] PB_OUT,
    output logic [PB_W-1:0] PB_OE,
    input wire logic [PD_W-1:0] PD_IN,
    output logic [PD_W-1:0] PD_OUT,
    output logic [PD_W-1:0] PD_OE
);
    function automatic src_alu_t alu2(input logic [1:0] f,
                                      input logic [DW-1:0] a,
                                      input logic [DW-1:0] b);
        src_alu_t r;
        logic [DW:0] s;
        s = '0;
        case (f)
            F2_ADD: s = {1'b0, a} + {1'b0, b};
            F2_SUB: s = {1'b0, a} - {1'b0, b};
            F2_AND: s = {1'b0, a & b};
            F2_OR: s = {1'b0, a | b};
        endcase
        r.res = s[DW-1:0];
        r.c = s[DW];
        return r;
    endfunction : alu2
    function automatic src_alu_t alu1(input logic [2:0] f,
                                      input logic [DW-1:0] a);
        src_alu_t r;
        r.res = a;
        r.c = 1'b0;
        unique case (f)
            F1_COM: r = '{res: ~a, c: 1'b1};
            F1_NEG: r = '{res: DW'(8'h00 - a), c: |a};
            F1_INC: r = '{res: DW'(a + 8'h01), c: &a};
            F1_DEC: r = '{res: DW'(a - 8'h01), c: ~|a};
            F1_LSR: r = '{res: a >> 1, c: a[0]};
            F1_SWAP: r = '{res: {a[3:0], a[7:4]}, c: 1'b0};
            default: r = '{res: a, c: 1'b0};
        endcase
        return r;
    endfunction : alu1
    // lowest set request wins, so a smaller vector means higher priority
    function automatic logic [IRQ_IW-1:0] first_set(
            input logic [NUM_IRQ-1:0] p);
        logic [IRQ_IW-1:0] k;
        k = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (p[i]) begin
                k = IRQ_IW'(i);
            end
        end
        return k;
    endfunction : first_set
    function automatic logic io_internal(input logic [IO_AW-1:0] a);
        return a == IO_STATUS || a == IO_SLEEPCTL || a == IO_PB_DATA ||
               a == IO_PB_DIR || a == IO_PB_PIN || a == IO_PD_DATA ||
               a == IO_PD_DIR || a == IO_PD_PIN;
    endfunction : io_internal
    logic [DW-1:0] rf_q [RF_N];
    logic [IP_W-1:0] stk_q [STK_N];
    logic [1:0] stk_cnt_q;
    logic [IP_W-1:0] ip_q, ir_addr_q;
    logic [IW-1:0] ir_q;
    logic ir_v_q;
    src_state_t state_q, state_d;
    logic [DW-1:0] sreg_q, sreg_d, sleepctl_q;
    logic [PB_W-1:0] pb_data_q, pb_dir_q, pb_s1_q, pb_s2_q;
    logic [PD_W-1:0] pd_data_q, pd_dir_q, pd_s1_q, pd_s2_q;
    logic ext_s1_q, ext_s2_q;
    src_iobus_t io_q;
    logic [NUM_IRQ-1:0] ack_q;
    logic osc_stop_q, sleeping_q;
    // decode fields
    wire [3:0] opc = ir_q[15:12];
    wire [RF_AW-1:0] rr_d = ir_q[9:5];
    wire [RF_AW-1:0] rr_r = ir_q[4:0];
    wire [RF_AW-1:0] imm_d = {1'b1, ir_q[11:8]};
    wire [DW-1:0] imm_k = ir_q[7:0];
    wire [IO_AW-1:0] io_a = ir_q[10:5];
    wire [IP_W-1:0] rel_k = ir_q[8:0];
    // interrupts: external pin is source 0, peripherals follow
    wire ext_req = ~ext_s2_q;
    wire [NUM_IRQ-1:0] irq_pend = {IRQ_REQ, ext_req};
    wire [IRQ_IW-1:0] irq_idx = first_set(irq_pend);
    wire [IP_W-1:0] irq_vec = VEC_BASE + IP_W'(irq_idx);
    wire irq_take = state_q == ST_RUN && ir_v_q && sreg_q[SR_I] &&
                    |irq_pend;
    wire exec = state_q == ST_RUN && ir_v_q && !irq_take;
    wire is_rr = exec && opc == OP_ALU_RR;
    wire is_imm = exec && (opc == OP_SUBI || opc == OP_ANDI ||
                           opc == OP_ORI);
    wire is_ldi = exec && opc == OP_LDI;
    wire is_r1 = exec && opc == OP_ALU_R;
    wire is_in = exec && opc == OP_IN;
    wire is_out = exec && opc == OP_OUT;
    wire is_jmp = exec && opc == OP_RJMP;
    wire is_call = exec && opc == OP_RCALL;
    wire is_ret = exec && opc == OP_RET;
    wire is_sleep = exec && opc == OP_SLEEP && sleepctl_q[SC_SE];
    wire is_gie = exec && opc == OP_GIE;
    wire in_ext = is_in && !io_internal(io_a);
    // only mapped addresses land on internal state; others go out
    wire out_int = is_out && io_internal(io_a);
    // alu paths share one operand read port pair
    wire [DW-1:0] op_a = is_imm ? rf_q[imm_d] : rf_q[rr_d];
    wire [DW-1:0] op_b = is_imm ? imm_k : rf_q[rr_r];
    wire [1:0] f2 = is_imm ? opc[1:0] : ir_q[11:10];
    wire src_alu_t r2 = alu2(f2, op_a, op_b);
    wire src_alu_t r1 = alu1(ir_q[7:5], rf_q[rr_r]);
    wire src_alu_t alu_r = is_r1 ? r1 : r2;
    // internal i/o read selection
    wire [DW-1:0] io_rd_int =
        io_a == IO_STATUS ? sreg_q :
        io_a == IO_SLEEPCTL ? sleepctl_q :
        io_a == IO_PB_DATA ? pb_data_q :
        io_a == IO_PB_DIR ? pb_dir_q :
        io_a == IO_PB_PIN ? pb_s2_q :
        io_a == IO_PD_DATA ? DW'(pd_data_q) :
        io_a == IO_PD_DIR ? DW'(pd_dir_q) : DW'(pd_s2_q);
    // register file write-back selection
    wire wb_en = is_rr || is_imm || is_ldi || is_r1 ||
                 (is_in && !in_ext) || state_q == ST_IOWAIT;
    wire [RF_AW-1:0] wb_addr = is_imm || is_ldi ? imm_d :
                               is_rr ? rr_d : rr_r;
    wire [DW-1:0] wb_data = state_q == ST_IOWAIT ? IO_RDATA :
                            is_in ? io_rd_int :
                            is_ldi ? imm_k : alu_r.res;
    wire flag_we = is_rr || is_imm || is_r1;
    // program flow
    wire [IP_W-1:0] rel_tgt = IP_W'(ir_addr_q + 9'h001 + rel_k);
    wire flush = irq_take || is_jmp || is_call || is_ret;
    wire fetch_en = (state_q == ST_RUN && !in_ext && !is_sleep) ||
                    state_q == ST_IOWAIT;
    wire [IP_W-1:0] ip_d = irq_take ? irq_vec :
                           is_jmp || is_call ? rel_tgt :
                           is_ret ? stk_q[0] :
                           fetch_en ? IP_W'(ip_q + 9'h001) : ip_q;
    wire push = is_call || irq_take;
    // an interrupt returns to the instruction it displaced
    wire [IP_W-1:0] push_val = is_call ? IP_W'(ir_addr_q + 9'h001) :
                               ir_addr_q;
    always_comb begin
        sreg_d = sreg_q;
        if (flag_we) begin
            sreg_d[SR_C] = alu_r.c;
            sreg_d[SR_Z] = alu_r.res == 8'h00;
            sreg_d[SR_N] = alu_r.res[DW-1];
        end
        if (out_int && io_a == IO_STATUS) begin
            sreg_d = rf_q[rr_r];
        end
        if (is_gie) begin
            sreg_d[SR_I] = ir_q[0];
        end
        if (is_ret && ir_q[0]) begin
            sreg_d[SR_I] = 1'b1;
        end
        if (irq_take) begin
            sreg_d[SR_I] = 1'b0;
        end
    end
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (in_ext) begin
                    state_d = ST_IOWAIT;
                end else if (is_sleep) begin
                    state_d = sleepctl_q[SC_SM] ? ST_PDOWN : ST_IDLE;
                end
            end
            ST_IOWAIT: state_d = ST_RUN;
            ST_IDLE: begin
                if (|irq_pend) begin
                    state_d = ST_RUN;
                end
            end
            ST_PDOWN: begin
                if (ext_req) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end
    // data storage has no reset; contents survive both sleep modes
    always_ff @(posedge CLOCK) begin
        if (wb_en) begin
            rf_q[wb_addr] <= wb_data;
        end
    end
    // a full stack drops its oldest entry instead of stalling
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            stk_q <= '{default: '0};
            stk_cnt_q <= '0;
        end else if (push) begin
            stk_q <= '{push_val, stk_q[0], stk_q[1]};
            stk_cnt_q <= stk_cnt_q == 2'(STK_N) ? stk_cnt_q :
                         2'(stk_cnt_q + 2'h1);
        end else if (is_ret) begin
            stk_q <= '{stk_q[1], stk_q[2], stk_q[2]};
            stk_cnt_q <= stk_cnt_q == 2'h0 ? stk_cnt_q :
                         2'(stk_cnt_q - 2'h1);
        end
    end
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ip_q <= IP_RESET;
            ir_q <= '0;
            ir_addr_q <= IP_RESET;
            ir_v_q <= 1'b0;
            state_q <= ST_RUN;
        end else begin
            ip_q <= ip_d;
            state_q <= state_d;
            if (fetch_en) begin
                ir_q <= PMEM_DATA;
                ir_addr_q <= ip_q;
            end
            ir_v_q <= fetch_en && !flush;
        end
    end
    // reset is honoured without a clock, so pins float at once
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            sreg_q <= '0;
            sleepctl_q <= '0;
            pb_data_q <= '0;
            pb_dir_q <= '0;
            pd_data_q <= '0;
            pd_dir_q <= '0;
        end else begin
            sreg_q <= sreg_d;
            if (out_int && io_a == IO_SLEEPCTL) begin
                sleepctl_q <= rf_q[rr_r];
            end
            if (out_int && io_a == IO_PB_DATA) begin
                pb_data_q <= rf_q[rr_r];
            end
            if (out_int && io_a == IO_PB_DIR) begin
                pb_dir_q <= rf_q[rr_r];
            end
            if (out_int && io_a == IO_PD_DATA) begin
                pd_data_q <= rf_q[rr_r][PD_W-1:0];
            end
            if (out_int && io_a == IO_PD_DIR) begin
                pd_dir_q <= rf_q[rr_r][PD_W-1:0];
            end
        end
    end
    // pin synchronisers
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pb_s1_q <= '0;
            pb_s2_q <= '0;
            pd_s1_q <= '0;
            pd_s2_q <= '0;
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
        end else begin
            pb_s1_q <= PB_IN;
            pb_s2_q <= pb_s1_q;
            pd_s1_q <= PD_IN;
            pd_s2_q <= pd_s1_q;
            ext_s1_q <= EXT_INT_N;
            ext_s2_q <= ext_s1_q;
        end
    end
    // external i/o strobes and status outputs, one cycle after execute
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            io_q <= '0;
            ack_q <= '0;
            osc_stop_q <= 1'b0;
            sleeping_q <= 1'b0;
        end else begin
            io_q.addr <= is_in || is_out ? io_a : io_q.addr;
            io_q.wdata <= is_out ? rf_q[rr_r] : io_q.wdata;
            io_q.we <= is_out && !out_int;
            io_q.re <= in_ext;
            ack_q <= irq_take ? NUM_IRQ'(1 << irq_idx) : '0;
            osc_stop_q <= state_d == ST_PDOWN;
            sleeping_q <= state_d == ST_IDLE || state_d == ST_PDOWN;
        end
    end
    assign PMEM_ADDR = ip_q;
    assign IO_BUS = io_q;
    assign IRQ_ACK = ack_q;
    assign OSC_STOP = osc_stop_q;
    assign SLEEPING = sleeping_q;
    assign PB_OUT = pb_data_q;
    assign PB_OE = pb_dir_q;
    assign PD_OUT = pd_data_q;
    assign PD_OE = pd_dir_q;
    a_rf_writeback: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        wb_en |=> rf_q[$past(wb_addr)] == $past(wb_data))
        else $error("register write-back lost");
    a_ip_sequential: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        exec && !flush && !in_ext && !is_sleep |=>
            ip_q == IP_W'($past(ip_q) + 9'h001) && ir_v_q)
        else $error("prefetch did not advance");
    a_fetch_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        fetch_en |=> ir_addr_q == $past(ip_q) && ir_q == $past(PMEM_DATA))
        else $error("fetched word not latched");
    a_rel_target: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        is_jmp |=> ip_q == IP_W'($past(ir_addr_q) + 9'h001 +
                                 $past(ir_q[8:0])))
        else $error("relative target wrong");
    a_stack_bound: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        push |=> stk_q[0] == $past(push_val) && stk_cnt_q <= 2'(STK_N))
        else $error("stack push wrong");
    a_gie_gates: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        irq_take |-> sreg_q[SR_I] ##1 !sreg_q[SR_I])
        else $error("interrupt taken while disabled");
    a_irq_priority: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        irq_take && irq_pend[0] |=> ip_q == VEC_BASE && ack_q[0])
        else $error("lowest vector not served first");
    a_idle_frozen: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        state_q == ST_IDLE && !(|irq_pend) |=>
            state_q == ST_IDLE && $stable(ip_q) && sleeping_q)
        else $error("idle did not hold execution");
    a_pdown_osc: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        state_q == ST_PDOWN && !ext_req |-> osc_stop_q ##1 state_q == ST_PDOWN)
        else $error("power-down left without wake");
    a_pins_float: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(RESET_N) |-> PB_OE == '0 && PD_OE == '0)
        else $error("pins driven out of reset");
    a_flush_prefetch: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        flush |=> !ir_v_q ##1 ir_addr_q == $past(ip_q))
        else $error("prefetched word not discarded");

endmodule : src_core
`default_nettype wire

// ==== rtl/src_pkg.sv ====
// package: constants, carrier types and codes for the small core control
`default_nettype none
package src_pkg;
    localparam int DW = 8;
    localparam int RF_N = 32;
    localparam int RF_AW = 5;
    localparam int IW = 16;
    localparam int IP_W = 9;
    localparam int IO_AW = 6;
    localparam int STK_N = 3;
    localparam int NUM_IRQ = 3;
    localparam int NUM_PIRQ = NUM_IRQ - 1;
    localparam int IRQ_IW = 2;
    localparam int PB_W = 8;
    localparam int PD_W = 7;
    // reset pulse width and the cycles it spans, rounded up
    localparam int RST_MIN_NS = 50;
    localparam int CLK_NS = 40;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    // program addresses
    localparam logic [IP_W-1:0] IP_RESET = 9'h000;
    localparam logic [IP_W-1:0] VEC_BASE = 9'h001;
    // opcodes in instruction bits 15..12
    localparam logic [3:0] OP_ALU_RR = 4'h0;
    localparam logic [3:0] OP_SUBI = 4'h1;
    localparam logic [3:0] OP_ANDI = 4'h2;
    localparam logic [3:0] OP_ORI = 4'h3;
    localparam logic [3:0] OP_LDI = 4'h4;
    localparam logic [3:0] OP_ALU_R = 4'h5;
    localparam logic [3:0] OP_IN = 4'h6;
    localparam logic [3:0] OP_OUT = 4'h7;
    localparam logic [3:0] OP_RJMP = 4'h8;
    localparam logic [3:0] OP_RCALL = 4'h9;
    localparam logic [3:0] OP_RET = 4'ha;
    localparam logic [3:0] OP_SLEEP = 4'hb;
    localparam logic [3:0] OP_GIE = 4'hd;
    // two-operand functions
    localparam logic [1:0] F2_ADD = 2'h0;
    localparam logic [1:0] F2_SUB = 2'h1;
    localparam logic [1:0] F2_AND = 2'h2;
    localparam logic [1:0] F2_OR = 2'h3;
    // single-operand functions
    localparam logic [2:0] F1_COM = 3'h0;
    localparam logic [2:0] F1_NEG = 3'h1;
    localparam logic [2:0] F1_INC = 3'h2;
    localparam logic [2:0] F1_DEC = 3'h3;
    localparam logic [2:0] F1_LSR = 3'h4;
    localparam logic [2:0] F1_SWAP = 3'h5;
    // internal i/o locations
    localparam logic [IO_AW-1:0] IO_STATUS = 6'h3f;
    localparam logic [IO_AW-1:0] IO_SLEEPCTL = 6'h35;
    localparam logic [IO_AW-1:0] IO_PB_DATA = 6'h18;
    localparam logic [IO_AW-1:0] IO_PB_DIR = 6'h17;
    localparam logic [IO_AW-1:0] IO_PB_PIN = 6'h16;
    localparam logic [IO_AW-1:0] IO_PD_DATA = 6'h12;
    localparam logic [IO_AW-1:0] IO_PD_DIR = 6'h11;
    localparam logic [IO_AW-1:0] IO_PD_PIN = 6'h10;
    // status and sleep control bits
    localparam int SR_I = 7;
    localparam int SR_N = 2;
    localparam int SR_Z = 1;
    localparam int SR_C = 0;
    localparam int SC_SE = 5;
    localparam int SC_SM = 4;

    typedef enum logic [1:0] {ST_RUN, ST_IOWAIT, ST_IDLE, ST_PDOWN} src_state_t;

    typedef struct packed {
        logic [IO_AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic we;
        logic re;
    } src_iobus_t;

    typedef struct packed {
        logic [DW-1:0] res;
        logic c;
    } src_alu_t;
endpackage : src_pkg
`default_nettype wire

// ==== bench/src_mem.sv ====
// partner model: program memory, external i/o and interrupt sources
`timescale 1ns/10ps
`default_nettype none
module src_mem
    import src_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [IP_W-1:0] PMEM_ADDR,
    output logic [IW-1:0] PMEM_DATA,
    input wire src_iobus_t IO_BUS,
    output logic [DW-1:0] IO_RDATA,
    input wire logic [NUM_IRQ-1:0] IRQ_ACK,
    output logic [NUM_PIRQ-1:0] IRQ_REQ,
    input wire logic [DW-1:0] rd_val
);
    logic [IW-1:0] rom [512];
    logic [DW-1:0] junk_q;
    logic [NUM_PIRQ-1:0] req_q;
    initial begin
        foreach (rom[i]) rom[i] = 16'hc000;
    end
    // own bus, one word per address, answered at once
    assign PMEM_DATA = rom[PMEM_ADDR];
    // churns outside a read strobe, so a late sample shows up
    assign IO_RDATA = IO_BUS.re ? rd_val : junk_q;
    assign IRQ_REQ = req_q;
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            junk_q <= 8'h5a;
            req_q <= '0;
        end else begin
            junk_q <= ~junk_q + 8'h01;
            // a write to 01 raises requests, an ack drops its own
            if (IO_BUS.we && IO_BUS.addr == 6'h01)
                req_q <= (req_q | IO_BUS.wdata[1:0]) & ~IRQ_ACK[2:1];
            else
                req_q <= req_q & ~IRQ_ACK[2:1];
        end
    end
endmodule : src_mem
`default_nettype wire

// ==== bench/small_risc_core_control_bench.sv ====
// self-checking bench for the core control
`timescale 1ns/10ps
`default_nettype none
module small_risc_core_control_bench
    import src_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic ext_int_n = 1'b1;
    logic run = 1'b1;
    logic [DW-1:0] rd_val = 8'h00;
    logic [PB_W-1:0] pb_in;
    logic [PD_W-1:0] pd_in;
    logic [IP_W-1:0] pmem_addr;
    logic [IW-1:0] pmem_data;
    src_iobus_t io_bus;
    logic [DW-1:0] io_rdata;
    logic [NUM_PIRQ-1:0] irq_req;
    logic [NUM_IRQ-1:0] irq_ack;
    logic osc_stop, sleeping;
    logic [PB_W-1:0] pb_oe, pb_out;
    logic [PD_W-1:0] pd_oe, pd_out;
    logic [31:0] seed = 32'hf7e6;
    logic [13:0] q [$];
    logic [13:0] exp_w;
    logic [3:0] imm [3] = '{OP_SUBI, OP_ANDI, OP_ORI};
    logic [7:0] cl [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h13, 8'h12, 8'h11};
    int fails = 0;
    int n_tests = 0;
    int ptr, m;

    always #20 clock = run ? ~clock : clock;

    src_core src_core_i (.CLOCK(clock), .RESET_N(reset_n),
        .PMEM_ADDR(pmem_addr), .PMEM_DATA(pmem_data), .IO_BUS(io_bus),
        .IO_RDATA(io_rdata), .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack),
        .EXT_INT_N(ext_int_n), .OSC_STOP(osc_stop), .SLEEPING(sleeping),
        .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe), .PD_IN(pd_in),
        .PD_OUT(pd_out), .PD_OE(pd_oe));
    src_mem src_mem_i (.CLOCK(clock), .RESET_N(reset_n),
        .PMEM_ADDR(pmem_addr), .PMEM_DATA(pmem_data), .IO_BUS(io_bus),
        .IO_RDATA(io_rdata), .IRQ_ACK(irq_ack), .IRQ_REQ(irq_req),
        .rd_val(rd_val));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] ex(input int k, input logic [7:0] a, b);
        case (k)
            0: return a + b;
            1, 4: return a - b;
            2, 5: return a & b;
            3, 6: return a | b;
            7: return ~a;
            8: return -a;
            9: return a + 8'h01;
            10: return a - 8'h01;
            11: return a >> 1;
            default: return {a[3:0], a[7:4]};
        endcase
    endfunction : ex
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic w(input logic [15:0] x);
        src_mem_i.rom[ptr] = x;
        ptr = (ptr + 1) % 512;
    endtask : w
    task automatic out(input logic [5:0] a, input logic [4:0] r,
                       input logic [7:0] e, input bit p);
        w({OP_OUT, 1'b0, a, r});
        if (p) q.push_back({a, e});
    endtask : out
    task automatic ldi(input logic [4:0] d, input logic [7:0] k);
        w({OP_LDI, d[3:0], k});
    endtask : ldi
    task automatic mark(input logic [7:0] n, input bit p);
        ldi(5'd20, n);
        out(6'h02, 5'd20, n, p);
    endtask : mark
    task automatic jmp(input logic [3:0] op, input int t);
        w({op, 3'h0, 9'(t - ptr - 1)});
    endtask : jmp
    function automatic bit cond(input int c);
        case (c)
            0: return sleeping === 1'b1 && osc_stop === 1'b0;
            1: return osc_stop === 1'b1;
            2: return irq_ack[0] === 1'b1;
            default: return q.size() == 0;
        endcase
    endfunction : cond
    task automatic waitfor(input int c);
        for (int i = 0; i < 3000 && !cond(c); i++) begin
            @(posedge clock);
            #2;
        end
        if (!cond(c)) begin
            fails++;
            report_and_stop();
        end
    endtask : waitfor
    // sleep, check fetch frozen, wake by the external pin
    task automatic nap(input int c);
        logic [IP_W-1:0] a;
        waitfor(c);
        a = pmem_addr;
        repeat (5) @(posedge clock);
        #2;
        chk(16'(pmem_addr), 16'(a));
        chk(16'(sleeping), 16'h0001);
        ext_int_n = 1'b0;
        waitfor(2);
        ext_int_n = 1'b1;
        $display("test done: sleep mode %0d", c);
    endtask : nap

    always @(negedge clock) begin
        if (reset_n && io_bus.we === 1'b1) begin
            exp_w = (q.size() > 0) ? q.pop_front() : 14'h3fff;
            chk({2'b00, io_bus.addr, io_bus.wdata}, {2'b00, exp_w});
        end
    end

    initial begin
        pb_in = seed[7:0];
        pd_in = seed[14:8];
        #1;
        ptr = 0;
        jmp(OP_RJMP, 8);
        for (int i = 0; i < 3; i++) jmp(OP_RJMP, 'h1f0 + 4 * i);
        for (int i = 0; i < 3; i++) begin
            ptr = 'h1f0 + 4 * i;
            mark(8'(8'ha0 + i), 1'b0);
            w(16'ha001);
        end
        ptr = 8;
        for (int k = 0; k < 13; k++) begin
            seed = lfsr(seed);
            ldi(5'd18, seed[7:0]);
            ldi(5'd17, seed[15:8]);
            if (k < 4) w({OP_ALU_RR, 2'(k), 5'd18, 5'd17});
            else if (k < 7) w({imm[k-4], 4'h2, seed[15:8]});
            else w({OP_ALU_R, 4'h0, 3'(k - 7), 5'd18});
            out(6'h02, 5'd18, ex(k, seed[7:0], seed[15:8]), 1'b1);
        end
        seed = lfsr(seed);
        rd_val = seed[7:0];
        w({OP_IN, 1'b0, 6'h03, 5'd5});
        out(6'h02, 5'd5, seed[7:0], 1'b1);
        // pin reads come back through the synchronisers
        w({OP_IN, 1'b0, IO_PB_PIN, 5'd6});
        w({OP_IN, 1'b0, IO_PD_PIN, 5'd7});
        out(6'h02, 5'd6, pb_in, 1'b1);
        out(6'h02, 5'd7, 8'(pd_in), 1'b1);
        out(IO_PB_DATA, 5'd5, 8'h00, 1'b0);
        out(IO_PD_DATA, 5'd5, 8'h00, 1'b0);
        jmp(OP_RJMP, 'h1c0);
        out(6'h02, 5'd18, 8'h00, 1'b0);
        m = ptr;
        ptr = 'h1c0;
        mark(8'h5a, 1'b1);
        jmp(OP_RJMP, m);
        ptr = m;
        jmp(OP_RCALL, 'h110);
        m = ptr;
        for (int n = 1; n < 5; n++) begin
            ptr = 'h100 + 16 * n;
            mark(8'(n), 1'b0);
            if (n < 4) jmp(OP_RCALL, 'h110 + 16 * n);
            if (n < 4) mark(8'(16 + n), 1'b0);
            if (n == 1) jmp(OP_RJMP, m);
            else w(16'ha000);
        end
        ptr = m;
        foreach (cl[i]) q.push_back({6'h02, cl[i]});
        // both requests pend while interrupts are still off
        ldi(5'd21, 8'h03);
        out(6'h01, 5'd21, 8'h03, 1'b1);
        mark(8'h77, 1'b1);
        w(16'hd001);
        q.push_back({6'h02, 8'ha1});
        q.push_back({6'h02, 8'ha2});
        ldi(5'd22, 8'hff);
        out(IO_PB_DIR, 5'd22, 8'hff, 1'b0);
        out(IO_PD_DIR, 5'd22, 8'hff, 1'b0);
        ldi(5'd20, 8'h20);
        out(IO_SLEEPCTL, 5'd20, 8'h20, 1'b0);
        w(16'hb000);
        w(16'hc000);
        w(16'hc000);
        q.push_back({6'h02, 8'ha0});
        mark(8'h66, 1'b1);
        ldi(5'd20, 8'h30);
        out(IO_SLEEPCTL, 5'd20, 8'h30, 1'b0);
        ldi(5'd21, 8'h3c);
        w(16'hb000);
        w(16'hc000);
        w(16'hc000);
        q.push_back({6'h02, 8'ha0});
        out(6'h02, 5'd21, 8'h3c, 1'b1);
        w(16'h81ff);
        repeat (3) @(posedge clock);
        #2;
        reset_n = 1'b1;
        nap(0);
        nap(1);
        waitfor(3);
        $display("test done: program run");
        chk(16'(pb_oe), 16'h00ff);
        chk(16'(pd_oe), 16'h007f);
        chk(16'(pb_out), 16'(rd_val));
        chk(16'(pd_out), 16'(rd_val[6:0]));
        // clock stopped: reset must still clear outputs at once
        run = 1'b0;
        #60;
        reset_n = 1'b0;
        #60;
        chk(16'(pb_oe), 16'h0000);
        chk(16'(pd_oe), 16'h0000);
        chk(16'(pmem_addr), 16'h0000);
        chk(16'({pb_out, pd_out}), 16'h0000);
        $display("test done: reset without clock");
        report_and_stop();
    end
endmodule : small_risc_core_control_bench
`default_nettype wire
